/* File: src/acr_chan_ramp.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_chan_ramp
    import acr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // timing
    input wire logic fs_tick,
    input wire logic [5:0] step_interval,
    // level
    input wire logic [7:0] target,
    output logic [7:0] level,
    output logic busy
);
    logic [7:0] tgt, next_tgt, next_level;
    logic [5:0] cnt, next_cnt;
    logic next_busy;

    always_comb begin
        next_tgt = tgt;
        next_level = level;
        next_cnt = cnt;
        next_busy = busy;
        if (fs_tick) begin
            if (!busy) begin
                // a new target is only taken once the previous ramp is done
                if (target != level) begin
                    next_tgt = target;
                    next_busy = 1'b1;
                    next_cnt = 6'h00;
                end
            end else if (cnt >= step_interval - 6'h01) begin
                next_cnt = 6'h00;
                if (level < tgt) begin
                    next_level = level + 8'h01;
                end else if (level > tgt) begin
                    next_level = level - 8'h01;
                end
                if (next_level == tgt) begin
                    next_busy = 1'b0;
                end
            end else begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tgt <= ACR_LEVEL_DEFAULT;
            level <= ACR_LEVEL_DEFAULT;
            cnt <= 6'h00;
            busy <= 1'b0;
        end else if (ce) begin
            tgt <= next_tgt;
            level <= next_level;
            cnt <= next_cnt;
            busy <= next_busy;
        end
    end
endmodule // acr_chan_ramp
`default_nettype wire

/* File: src/acr_pair_fade.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_pair_fade
    import acr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // control
    input wire logic fs_tick,
    input wire logic save,
    // status
    output logic [7:0] gain,
    output logic powered_down,
    output logic data_reset
);
    typedef enum logic [1:0] {ACR_RUN, ACR_FADE_OUT, ACR_DOWN, ACR_FADE_IN} acr_fade_state_t;
    acr_fade_state_t state, next_state;
    logic [7:0] next_gain;

    always_comb begin
        next_state = state;
        next_gain = gain;
        case (state)
            ACR_RUN: begin
                if (save) begin
                    next_state = ACR_FADE_OUT;
                end
            end
            ACR_FADE_OUT: begin
                if (!save) begin
                    next_state = ACR_FADE_IN;
                end else if (gain == 8'h00) begin
                    next_state = ACR_DOWN;
                end else if (fs_tick) begin
                    next_gain = gain - 8'h01;
                end
            end
            ACR_DOWN: begin
                if (!save) begin
                    next_state = ACR_FADE_IN;
                end
            end
            ACR_FADE_IN: begin
                if (save) begin
                    next_state = ACR_FADE_OUT;
                end else if (gain == ACR_GAIN_FULL) begin
                    next_state = ACR_RUN;
                end else if (fs_tick) begin
                    next_gain = gain + 8'h01;
                end
            end
            default: begin
                next_state = ACR_RUN;
                next_gain = ACR_GAIN_FULL;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ACR_RUN;
            gain <= ACR_GAIN_FULL;
        end else if (ce) begin
            state <= next_state;
            gain <= next_gain;
        end
    end

    assign powered_down = (state == ACR_DOWN);
    assign data_reset = (state == ACR_DOWN);
endmodule // acr_pair_fade
`default_nettype wire

/* File: src/acr_pkg.sv */
// What this block does
// RQ1: role field: slave at 000, four master ratios
// RQ2: format default 24-bit I2S, LJ, RJ, 16-bit RJ
// RQ3: format codes 100-111 give DSP and TDM
// RQ4: pair power-save fades out, resets, powers down
// RQ5: release fades in; registers stay usable
// RQ6: host waits settle delay after power-save change
// RQ7: bypass bit per pair disables high-pass filter
// RQ8: input bit per channel: differential or single-ended
// RQ9: phase bit per channel inverts analog input
// RQ10: mute ramps attenuator to infinite attenuation
// RQ11: unmute ramps back to last programmed level
// RQ12: mute overrides programmed level in same attenuator
// RQ13: sticky overflow flags, any read clears all (code: only a read of ACR_OFS_OVERFLOW clears)
// RQ14: mode bit: own level, or master plus own
// RQ15: speed bit: N x 2048 or N x 4096 samples
// RQ16: N is 1 single rate, 2 dual rate
// RQ17: polarity 0: overflow pin high on overflow
// RQ18: polarity 1: overflow pin low on overflow
// RQ19: sampling mode auto, forced single, forced dual
// RQ20: level code 215 is 0 dB, 14 down mutes
package acr_pkg;
    // ********
    // register offsets
    // ********
    localparam logic [7:0] ACR_OFS_SAMPLING = 8'h50;
    localparam logic [7:0] ACR_OFS_ROLE_FMT = 8'h51;
    localparam logic [7:0] ACR_OFS_PSAVE_BYP = 8'h52;
    localparam logic [7:0] ACR_OFS_INPUT_CFG = 8'h53;
    localparam logic [7:0] ACR_OFS_INPUT_PHASE = 8'h54;
    localparam logic [7:0] ACR_OFS_SOFT_MUTE = 8'h55;
    localparam logic [7:0] ACR_OFS_OVERFLOW = 8'h56;
    localparam logic [7:0] ACR_OFS_ATT_POL = 8'h57;
    localparam logic [7:0] ACR_OFS_LEVEL_MASTER = 8'h58;
    localparam logic [7:0] ACR_OFS_LEVEL_LAST = 8'h5e;
    // ********
    // field positions and reset values
    // ********
    localparam int ACR_ROLE_LSB = 4;
    localparam int ACR_PSAVE_LSB = 4;
    localparam int ACR_ATT_MODE_BIT = 7;
    localparam int ACR_ATT_SPEED_BIT = 6;
    localparam int ACR_OVF_POL_BIT = 0;
    localparam logic [7:0] ACR_RESET_ZERO = 8'h00;
    localparam logic [7:0] ACR_LEVEL_DEFAULT = 8'hd7;
    localparam logic [7:0] ACR_LEVEL_MUTE_MAX = 8'h0e;
    localparam logic [7:0] ACR_LEVEL_MAX = 8'hff;
    localparam logic [7:0] ACR_GAIN_FULL = 8'hff;
    // ********
    // codes
    // ********
    localparam logic [2:0] ACR_ROLE_SLAVE = 3'h0;
    localparam logic [2:0] ACR_ROLE_768 = 3'h1;
    localparam logic [2:0] ACR_ROLE_512 = 3'h2;
    localparam logic [2:0] ACR_ROLE_384 = 3'h3;
    localparam logic [2:0] ACR_ROLE_256 = 3'h4;
    localparam logic [1:0] ACR_SR_AUTO = 2'h0;
    localparam logic [1:0] ACR_SR_SINGLE = 2'h1;
    localparam logic [1:0] ACR_SR_DUAL = 2'h2;
    // ********
    // ramp timing, in sample periods
    // ********
    localparam int ACR_RAMP_BASE_SAMPLES = 2048;
    localparam int ACR_LEVEL_STEPS = 256;
    localparam logic [5:0] ACR_STEP_BASE = 6'(ACR_RAMP_BASE_SAMPLES / ACR_LEVEL_STEPS);
endpackage

/* File: src/acr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_regs
    import acr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // converter side inputs
    input wire logic fs_tick,
    input wire logic [2:0] slave_clock_ratio,
    input wire logic [5:0] overflow_event,
    // interface configuration
    output logic adc_master,
    output logic [2:0] adc_interface_role,
    output logic [2:0] adc_serial_format,
    output logic fmt_word16,
    output logic fmt_right_justified,
    output logic fmt_left_justified,
    output logic fmt_i2s,
    output logic fmt_dsp,
    output logic fmt_tdm,
    output logic dual_rate,
    // analog and filter control
    output logic [2:0] highpass_bypass,
    output logic [5:0] adc_input_single_ended,
    output logic [5:0] adc_input_invert,
    // power-save
    output logic [2:0] pair_powered_down,
    output logic [2:0] pair_data_reset,
    output logic [23:0] pair_fade_gain,
    // attenuators
    output logic [47:0] adc_channel_level,
    output logic [5:0] ramp_busy,
    // overflow pin
    output logic overflow_pin
);
    // ********
    // helpers
    // ********
    function automatic logic is_muted(input logic [7:0] code);
        is_muted = (code <= ACR_LEVEL_MUTE_MAX);
    endfunction

    // master plus own in dB: code = a + b - 215, held at +20 dB
    function automatic logic [7:0] eff_level(input logic [7:0] own, input logic [7:0] mst,
                                            input logic mode, input logic mute);
        logic [9:0] sum;
        sum = {2'b00, own} + {2'b00, mst} - {2'b00, ACR_LEVEL_DEFAULT};
        if (mute) begin
            eff_level = 8'h00; // RQ12
        end else if (!mode) begin
            eff_level = is_muted(own) ? 8'h00 : own; // RQ14
        end else if (is_muted(own) || is_muted(mst) || sum[9]) begin
            eff_level = 8'h00; // RQ20
        end else if (sum > {2'b00, ACR_LEVEL_MAX}) begin
            eff_level = ACR_LEVEL_MAX; // RQ14
        end else if (sum[7:0] <= ACR_LEVEL_MUTE_MAX) begin
            eff_level = 8'h00;
        end else begin
            eff_level = sum[7:0];
        end
    endfunction

    function automatic logic ratio_is_dual(input logic [2:0] ratio);
        ratio_is_dual = (ratio == ACR_ROLE_384) || (ratio == ACR_ROLE_256);
    endfunction

    // ********
    // register state
    // ********
    logic [1:0] sampling_mode, next_sampling_mode;
    logic [2:0] role, next_role;
    logic [2:0] fmt, next_fmt;
    logic [2:0] psave, next_psave;
    logic [2:0] bypass, next_bypass;
    logic [5:0] single_ended, next_single_ended;
    logic [5:0] invert, next_invert;
    logic [5:0] mute, next_mute;
    logic [5:0] ovf_flags, next_ovf_flags;
    logic att_mode, next_att_mode;
    logic att_speed, next_att_speed;
    logic ovf_pol, next_ovf_pol;
    logic [7:0] level_reg [0:6];
    logic [7:0] next_level_reg [0:6];
    logic [7:0] next_rdata;
    logic next_overflow_pin;
    logic level_hit;
    logic [2:0] level_idx;

    assign level_hit = (reg_addr >= ACR_OFS_LEVEL_MASTER) && (reg_addr <= ACR_OFS_LEVEL_LAST);
    assign level_idx = 3'(reg_addr - ACR_OFS_LEVEL_MASTER);

    always_comb begin
        next_sampling_mode = sampling_mode;
        next_role = role;
        next_fmt = fmt;
        next_psave = psave;
        next_bypass = bypass;
        next_single_ended = single_ended;
        next_invert = invert;
        next_mute = mute;
        next_att_mode = att_mode;
        next_att_speed = att_speed;
        next_ovf_pol = ovf_pol;
        for (int i = 0; i < 7; i++) begin
            next_level_reg[i] = level_reg[i];
        end
        // writes are accepted in every power-save state
        if (reg_wr) begin // RQ5
            case (reg_addr)
                ACR_OFS_SAMPLING: next_sampling_mode = reg_wdata[1:0];
                ACR_OFS_ROLE_FMT: begin
                    next_role = reg_wdata[ACR_ROLE_LSB +: 3]; // RQ1
                    next_fmt = reg_wdata[2:0]; // RQ2
                end
                ACR_OFS_PSAVE_BYP: begin
                    next_psave = reg_wdata[ACR_PSAVE_LSB +: 3]; // RQ4
                    next_bypass = reg_wdata[2:0]; // RQ7
                end
                ACR_OFS_INPUT_CFG: next_single_ended = reg_wdata[5:0]; // RQ8
                ACR_OFS_INPUT_PHASE: next_invert = reg_wdata[5:0]; // RQ9
                ACR_OFS_SOFT_MUTE: next_mute = reg_wdata[5:0]; // RQ10
                ACR_OFS_ATT_POL: begin
                    next_att_mode = reg_wdata[ACR_ATT_MODE_BIT]; // RQ14
                    next_att_speed = reg_wdata[ACR_ATT_SPEED_BIT]; // RQ15
                    next_ovf_pol = reg_wdata[ACR_OVF_POL_BIT]; // RQ17
                end
                default: begin
                    if (level_hit) begin
                        next_level_reg[level_idx] = reg_wdata; // RQ20
                    end
                end
            endcase
        end
    end

    // ********
    // read path and sticky overflow flags
    // ********
    always_comb begin
        next_rdata = reg_rdata;
        next_ovf_flags = ovf_flags;
        if (reg_rd) begin
            case (reg_addr)
                ACR_OFS_SAMPLING: next_rdata = {6'h00, sampling_mode};
                ACR_OFS_ROLE_FMT: next_rdata = {1'b0, role, 1'b0, fmt};
                ACR_OFS_PSAVE_BYP: next_rdata = {1'b0, psave, 1'b0, bypass};
                ACR_OFS_INPUT_CFG: next_rdata = {2'b00, single_ended};
                ACR_OFS_INPUT_PHASE: next_rdata = {2'b00, invert};
                ACR_OFS_SOFT_MUTE: next_rdata = {2'b00, mute};
                ACR_OFS_OVERFLOW: begin
                    next_rdata = {2'b00, ovf_flags};
                    next_ovf_flags = 6'h00; // RQ13
                end
                ACR_OFS_ATT_POL: next_rdata = {att_mode, att_speed, 5'h00, ovf_pol};
                default: next_rdata = level_hit ? level_reg[level_idx] : 8'h00;
            endcase
        end
        // a new event in the clearing cycle survives
        next_ovf_flags = next_ovf_flags | overflow_event; // RQ13
        next_overflow_pin = (|overflow_event) ^ ovf_pol; // RQ17 RQ18
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sampling_mode <= ACR_SR_AUTO;
            role <= ACR_ROLE_SLAVE;
            fmt <= ACR_RESET_ZERO[2:0];
            psave <= ACR_RESET_ZERO[2:0];
            bypass <= ACR_RESET_ZERO[2:0];
            single_ended <= ACR_RESET_ZERO[5:0];
            invert <= ACR_RESET_ZERO[5:0];
            mute <= ACR_RESET_ZERO[5:0];
            ovf_flags <= ACR_RESET_ZERO[5:0];
            att_mode <= 1'b0;
            att_speed <= 1'b0;
            ovf_pol <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                level_reg[i] <= ACR_LEVEL_DEFAULT;
            end
            reg_rdata <= ACR_RESET_ZERO;
            overflow_pin <= 1'b0;
        end else if (ce) begin
            sampling_mode <= next_sampling_mode;
            role <= next_role;
            fmt <= next_fmt;
            psave <= next_psave;
            bypass <= next_bypass;
            single_ended <= next_single_ended;
            invert <= next_invert;
            mute <= next_mute;
            ovf_flags <= next_ovf_flags;
            att_mode <= next_att_mode;
            att_speed <= next_att_speed;
            ovf_pol <= next_ovf_pol;
            for (int i = 0; i < 7; i++) begin
                level_reg[i] <= next_level_reg[i];
            end
            reg_rdata <= next_rdata;
            overflow_pin <= next_overflow_pin;
        end
    end

    // ********
    // interface role, format and sampling mode decode
    // ********
    logic [2:0] clock_ratio;
    logic [5:0] step_interval;
    logic is_master;

    assign is_master = (role >= ACR_ROLE_768) && (role <= ACR_ROLE_256); // RQ1
    assign clock_ratio = is_master ? role : slave_clock_ratio;

    always_comb begin
        case (sampling_mode) // RQ19
            ACR_SR_SINGLE: dual_rate = 1'b0;
            ACR_SR_DUAL: dual_rate = 1'b1;
            default: dual_rate = ratio_is_dual(clock_ratio);
        endcase
    end

    // step spacing: base x N x (1 or 2)
    assign step_interval = ACR_STEP_BASE << ({1'b0, dual_rate} + {1'b0, att_speed}); // RQ15 RQ16

    assign adc_master = is_master;
    assign adc_interface_role = role;
    assign adc_serial_format = fmt;
    assign fmt_word16 = (fmt == 3'h3); // RQ2
    assign fmt_right_justified = fmt inside {3'h2, 3'h3};
    assign fmt_left_justified = fmt inside {3'h1, 3'h5, 3'h7}; // RQ3
    assign fmt_i2s = fmt inside {3'h0, 3'h4, 3'h6};
    assign fmt_dsp = fmt inside {3'h4, 3'h5}; // RQ3
    assign fmt_tdm = fmt inside {3'h6, 3'h7}; // RQ3
    assign highpass_bypass = bypass; // RQ7
    assign adc_input_single_ended = single_ended; // RQ8
    assign adc_input_invert = invert; // RQ9

    // ********
    // per-pair power-save and per-channel attenuators
    // ********
    for (genvar p = 0; p < 3; p++) begin : g_pair
        acr_pair_fade u_fade (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .ce(ce),
            .fs_tick(fs_tick),
            .save(psave[p]), // RQ4 RQ5
            .gain(pair_fade_gain[8*p +: 8]),
            .powered_down(pair_powered_down[p]),
            .data_reset(pair_data_reset[p])
        );
    end

    for (genvar c = 0; c < 6; c++) begin : g_chan
        logic [7:0] target;
        assign target = eff_level(level_reg[c + 1], level_reg[0], att_mode, mute[c]); // RQ11 RQ12
        acr_chan_ramp u_ramp (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .ce(ce),
            .fs_tick(fs_tick),
            .step_interval(step_interval), // RQ15
            .target(target), // RQ10
            .level(adc_channel_level[8*c +: 8]),
            .busy(ramp_busy[c])
        );
    end
endmodule // acr_regs
`default_nettype wire

/* File: verification/acr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_host_model #(
    parameter int SETTLE_CYCLES = 16
) (
    // clock
    input wire logic mclk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // released lines show inverted values
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
    task automatic psave_wr(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        repeat (SETTLE_CYCLES) @(posedge mclk);
        #1;
    endtask
endmodule // acr_host_model
`default_nettype wire

/* File: verification/acr_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module acr_regs_checker
    import acr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] overflow_event,
    // observed outputs
    input wire logic adc_master,
    input wire logic [2:0] adc_interface_role,
    input wire logic [2:0] adc_serial_format,
    input wire logic fmt_tdm,
    input wire logic [2:0] highpass_bypass,
    input wire logic [5:0] adc_input_single_ended,
    input wire logic [5:0] adc_input_invert,
    input wire logic [2:0] pair_powered_down,
    input wire logic [23:0] pair_fade_gain,
    input wire logic [47:0] adc_channel_level
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_role_fmt_write: assert property (ce && reg_wr && reg_addr == ACR_OFS_ROLE_FMT |=>
        adc_interface_role == $past(reg_wdata[6:4]) && adc_serial_format == $past(reg_wdata[2:0]))
        else $error("role or format not taken from write");
    a_master_decode: assert property (adc_master == (adc_interface_role inside {[3'h1:3'h4]}))
        else $error("master decode wrong");
    a_tdm_decode: assert property (fmt_tdm == (adc_serial_format[2:1] == 2'b11))
        else $error("tdm decode wrong");
    a_bypass_write: assert property (ce && reg_wr && reg_addr == ACR_OFS_PSAVE_BYP |=>
        highpass_bypass == $past(reg_wdata[2:0])) else $error("bypass not taken");
    a_single_ended_write: assert property (ce && reg_wr && reg_addr == ACR_OFS_INPUT_CFG |=>
        adc_input_single_ended == $past(reg_wdata[5:0])) else $error("input config not taken");
    a_invert_write: assert property (ce && reg_wr && reg_addr == ACR_OFS_INPUT_PHASE |=>
        adc_input_invert == $past(reg_wdata[5:0])) else $error("input phase not taken");
    a_ovf_read_clear: assert property ((ce && reg_rd && reg_addr == ACR_OFS_OVERFLOW &&
        overflow_event == 6'h00) ##1 (overflow_event == 6'h00) ##1 (ce && reg_rd &&
        reg_addr == ACR_OFS_OVERFLOW && overflow_event == 6'h00) |=> reg_rdata == 8'h00)
        else $error("overflow flags not cleared by read");
    a_rdata_holds: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without read");
    a_down_silent: assert property (pair_powered_down[0] |-> pair_fade_gain[7:0] == 8'h00)
        else $error("pair down with nonzero gain");
    a_level_unit_step: assert property (!$stable(adc_channel_level[7:0]) |->
        (adc_channel_level[7:0] - $past(adc_channel_level[7:0])) inside {8'h01, 8'hff})
        else $error("attenuator jumped by more than one code");
endmodule // acr_regs_checker

bind acr_regs acr_regs_checker i_acr_regs_checker (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .overflow_event(overflow_event), .adc_master(adc_master),
    .adc_interface_role(adc_interface_role), .adc_serial_format(adc_serial_format),
    .fmt_tdm(fmt_tdm), .highpass_bypass(highpass_bypass),
    .adc_input_single_ended(adc_input_single_ended), .adc_input_invert(adc_input_invert),
    .pair_powered_down(pair_powered_down), .pair_fade_gain(pair_fade_gain),
    .adc_channel_level(adc_channel_level));
`default_nettype wire

/* File: verification/tb_adc_channel_control_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_channel_control_registers;
    import acr_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic fs_tick = 1'b0;
    logic [2:0] slave_clock_ratio = ACR_ROLE_512;
    logic [5:0] overflow_event = 6'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, adc_master, fmt_word16, fmt_dsp, fmt_tdm, dual_rate, overflow_pin;
    logic fmt_right_justified, fmt_left_justified, fmt_i2s;
    logic [2:0] adc_interface_role, adc_serial_format;
    logic [2:0] highpass_bypass, pair_powered_down, pair_data_reset;
    logic [5:0] adc_input_single_ended, adc_input_invert, ramp_busy;
    logic [23:0] pair_fade_gain;
    logic [47:0] adc_channel_level;
    logic [1:0] tick_div = 2'h0;
    int tick_cnt = 0;
    int fails = 0;
    int n_compared = 0;

    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        tick_div <= tick_div + 2'h1;
        fs_tick <= (tick_div == 2'h3);
        tick_cnt <= tick_cnt + ((fs_tick === 1'b1) ? 1 : 0);
    end

    acr_regs i_acr_regs (.*);
    acr_host_model i_acr_host_model (.*);

    task automatic results;
        $display("compared %0d, fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick1;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_acr_host_model.wr(a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_acr_host_model.rd(a, d);
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_reset_values;
        logic [7:0] d, a;
        for (a = 8'h50; a != 8'h58; a++) begin
            rd(a, d);
            chk(d, ACR_RESET_ZERO);
        end
        rd(8'h59, d);
        chk(d, ACR_LEVEL_DEFAULT);
        rd(8'h60, d);
        chk(d, 8'h00);
    endtask
    task automatic t_role_format;
        logic [7:0] d, e;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            wr(ACR_OFS_ROLE_FMT, {1'b0, c, 1'b0, c});
            e = {1'b0, c inside {3'h0, 3'h4, 3'h6}, c inside {3'h1, 3'h5, 3'h7},
                c inside {3'h2, 3'h3}, c == 3'h3, c[2:1] == 2'b10, c[2:1] == 2'b11,
                c >= 3'h1 && c <= 3'h4};
            chk({1'b0, fmt_i2s, fmt_left_justified, fmt_right_justified, fmt_word16, fmt_dsp,
                fmt_tdm, adc_master}, e);
            rd(ACR_OFS_ROLE_FMT, d);
            chk(d, {1'b0, c, 1'b0, c});
        end
        wr(ACR_OFS_ROLE_FMT, 8'h00);
    endtask
    task automatic t_channel_bits;
        logic [7:0] d;
        wr(ACR_OFS_PSAVE_BYP, 8'h05);
        wr(ACR_OFS_INPUT_CFG, 8'h2a);
        wr(ACR_OFS_INPUT_PHASE, 8'h15);
        chk({5'h00, highpass_bypass}, 8'h05);
        chk({2'h0, adc_input_single_ended}, 8'h2a);
        chk({2'h0, adc_input_invert}, 8'h15);
        wr(ACR_OFS_PSAVE_BYP, 8'h8f);
        rd(ACR_OFS_PSAVE_BYP, d);
        chk(d, 8'h07);
        wr(ACR_OFS_PSAVE_BYP, 8'h00);
        // write with clock enable low must be ignored
        @(posedge mclk);
        ce <= 1'b0;
        wr(ACR_OFS_INPUT_CFG, 8'h01);
        @(posedge mclk);
        ce <= 1'b1;
        rd(ACR_OFS_INPUT_CFG, d);
        chk(d, 8'h2a);
    endtask
    task automatic t_overflow;
        logic [7:0] d;
        @(posedge mclk);
        overflow_event <= 6'h04;
        @(posedge mclk);
        overflow_event <= 6'h00;
        #1;
        chk({7'h00, overflow_pin}, 8'h01);
        rd(ACR_OFS_OVERFLOW, d);
        chk(d, 8'h04);
        rd(ACR_OFS_OVERFLOW, d);
        chk(d, 8'h00);
        wr(ACR_OFS_ATT_POL, 8'h01);
        tick1();
        chk({7'h00, overflow_pin}, 8'h01);
        @(posedge mclk);
        overflow_event <= 6'h20;
        @(posedge mclk);
        overflow_event <= 6'h00;
        #1;
        chk({7'h00, overflow_pin}, 8'h00);
        rd(ACR_OFS_OVERFLOW, d);
        chk(d, 8'h20);
        wr(ACR_OFS_ATT_POL, 8'h00);
    endtask
    task automatic t_rate_select;
        for (int i = 1; i < 5; i++) begin
            @(posedge mclk);
            slave_clock_ratio <= i[2:0];
            #1;
            chk({7'h00, dual_rate}, {7'h00, i >= 3});
        end
        @(posedge mclk);
        slave_clock_ratio <= ACR_ROLE_768;
        wr(ACR_OFS_SAMPLING, 8'h02);
        chk({7'h00, dual_rate}, 8'h01);
        @(posedge mclk);
        slave_clock_ratio <= ACR_ROLE_256;
        wr(ACR_OFS_SAMPLING, 8'h01);
        chk({7'h00, dual_rate}, 8'h00);
        wr(ACR_OFS_SAMPLING, 8'h00);
        @(posedge mclk);
        slave_clock_ratio <= ACR_ROLE_512;
    endtask
    task automatic t_power_save;
        logic [7:0] d;
        int i;
        i_acr_host_model.psave_wr(ACR_OFS_PSAVE_BYP, 8'h10);
        for (i = 0; i < 3000 && pair_powered_down[0] !== 1'b1; i++) tick1();
        chk(pair_fade_gain[7:0], 8'h00);
        chk({5'h00, pair_data_reset}, 8'h01);
        chk(pair_fade_gain[15:8], ACR_GAIN_FULL);
        rd(ACR_OFS_INPUT_CFG, d);
        chk(d, 8'h2a);
        i_acr_host_model.psave_wr(ACR_OFS_PSAVE_BYP, 8'h00);
        for (i = 0; i < 3000 && pair_fade_gain[7:0] !== ACR_GAIN_FULL; i++) tick1();
        tick1();
        chk(pair_fade_gain[7:0], ACR_GAIN_FULL);
        chk({5'h00, pair_powered_down}, 8'h00);
    endtask
    task automatic t_mute_ramp(input logic [7:0] mute, input logic [7:0] exp_level);
        int t0, i;
        wr(ACR_OFS_SOFT_MUTE, mute);
        for (i = 0; i < 20 && ramp_busy[0] !== 1'b1; i++) tick1();
        t0 = tick_cnt;
        for (i = 0; i < 12000 && ramp_busy[0] !== 1'b0; i++) tick1();
        chk({7'h00, (tick_cnt - t0) inside {[1712:1728]}}, 8'h01);
        chk(adc_channel_level[7:0], exp_level);
        chk(adc_channel_level[15:8], ACR_LEVEL_DEFAULT);
    endtask

    initial begin
        #1_000_000;
        fails++;
        results();
    end
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        tick1();
        t_reset_values();
        t_role_format();
        t_channel_bits();
        t_overflow();
        t_rate_select();
        t_power_save();
        t_mute_ramp(8'h01, 8'h00);
        t_mute_ramp(8'h00, ACR_LEVEL_DEFAULT);
        results();
    end
endmodule // tb_adc_channel_control_registers
`default_nettype wire
